// *** hw/sam_pkg.sv ***
// Package of constants for the SDRAM address and mask decode block.
package sam_pkg;
   localparam int ADDR_W = 12;
   localparam int BANK_W = 2;
   localparam int LANES = 4;
   localparam int DATA_W = 32;
   localparam int COL_W = 8;
   localparam int PRE_BIT = 10;
   localparam int MODE_W = ADDR_W + BANK_W;
   localparam int RD_MASK_LAT = 2;
   localparam logic [13:0] MODE_RST = 14'h0000;
   // Command codes as {cs_n, ras_n, cas_n, we_n}.
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_RD = 4'h5;
   localparam logic [3:0] CMD_WR = 4'h4;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_LMR = 4'h0;
endpackage

// *** hw/sam_decode.sv ***
// Input-side decode of SDRAM bank, address, mask and data pins.
// Function
// - Write data on a lane with its mask high is discarded; array byte kept.
// - Read lane mask high sets lane drivers to high impedance two clocks on.
// - Mask 0..3 govern data bits 7:0, 15:8, 23:16, 31:24.
// - Bank select with activate, read, write, precharge picks the bank.
// - Activate captures the address inputs as the row to open.
// - Read or write takes the start column from address bits 7:0.
// - Precharge closes all banks if bit 10 high, else the selected bank.
// - Load mode register loads the address op-code into the mode register.
// - Every input is sampled only on the rising clock edge.
// - Chip select, row and column strobes, write enable define the command.
// - Chip select high ignores commands; bursts and masks keep working.
module sam_decode
   import sam_pkg::*;
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_b,
   // Command pins.
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   // Address and bank pins.
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [BANK_W-1:0] bank_select,
   // Mask and data pins.
   input wire logic [LANES-1:0] byte_lane_mask,
   input wire logic [DATA_W-1:0] data_lines_in,
   output logic [DATA_W-1:0] data_lines_out,
   output logic [LANES-1:0] data_lines_oe_n,
   // Burst state from the core: a read or write burst is running.
   input wire logic rd_burst,
   input wire logic wr_burst,
   input wire logic [DATA_W-1:0] rd_data,
   // Decoded results toward the core.
   output logic act_q,
   output logic rd_q,
   output logic wr_q,
   output logic pre_q,
   output logic pre_all_q,
   output logic [BANK_W-1:0] bank_q,
   output logic [ADDR_W-1:0] row_q,
   output logic [COL_W-1:0] col_q,
   output logic auto_pre_q,
   output logic [MODE_W-1:0] mode_q,
   output logic [DATA_W-1:0] wdata_q,
   output logic [LANES-1:0] wr_en_q,
   output logic wvalid_q
);
   logic [3:0] cmd;
   logic [LANES-1:0] rmask_d1_q;

   // Pins are synchronous to mclk, so they are sampled directly.
   assign cmd = {cs_n, ras_n, cas_n, we_n};

   // Command strobes; a high chip select masks every command.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         act_q <= 1'b0;
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         pre_q <= 1'b0;
      end else begin
         act_q <= (cmd == CMD_ACT);
         rd_q <= (cmd == CMD_RD);
         wr_q <= (cmd == CMD_WR);
         pre_q <= (cmd == CMD_PRE);
      end
   end

   // Bank, row, column and precharge flags held from the last command.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         bank_q <= '0;
         row_q <= '0;
         col_q <= '0;
         auto_pre_q <= 1'b0;
         pre_all_q <= 1'b0;
      end else begin
         if (cmd == CMD_ACT || cmd == CMD_RD || cmd == CMD_WR ||
               cmd == CMD_PRE) begin
            bank_q <= bank_select;
         end
         if (cmd == CMD_ACT) begin
            row_q <= addr_in;
         end
         if (cmd == CMD_RD || cmd == CMD_WR) begin
            col_q <= addr_in[COL_W-1:0];
            auto_pre_q <= addr_in[PRE_BIT];
         end
         if (cmd == CMD_PRE) begin
            pre_all_q <= addr_in[PRE_BIT];
         end
      end
   end

   // Mode register takes bank select as its upper op-code bits.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         mode_q <= MODE_RST;
      end else if (cmd == CMD_LMR) begin
         mode_q <= {bank_select, addr_in};
      end
   end

   // Write masking has no latency and still works while chip select is
   // high, since a running burst must keep honouring the masks.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         wdata_q <= '0;
         wr_en_q <= '0;
         wvalid_q <= 1'b0;
      end else begin
         wdata_q <= data_lines_in;
         wvalid_q <= wr_burst;
         wr_en_q <= wr_burst ? ~byte_lane_mask : '0;
      end
   end

   // Read masks travel two stages; the first stage is the pin sample.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         rmask_d1_q <= '0;
         data_lines_oe_n <= '1;
         data_lines_out <= '0;
      end else begin
         rmask_d1_q <= byte_lane_mask;
         data_lines_out <= rd_data;
         for (int i = 0; i < LANES; i++) begin
            data_lines_oe_n[i] <= !rd_burst || rmask_d1_q[i];
         end
      end
   end

   property p_lane_mask;
      @(posedge mclk) disable iff (!rst_b)
         wr_burst && byte_lane_mask[0] |=> !wr_en_q[0];
   endproperty
   a_lane_mask: assert property (p_lane_mask)
      else $error("masked lane written");

   // Lane 2 checks the mask-to-byte pairing away from the low lane.
   property p_lane_two;
      @(posedge mclk) disable iff (!rst_b)
         wr_burst && byte_lane_mask[2] |=> !wr_en_q[2];
   endproperty
   a_lane_two: assert property (p_lane_two)
      else $error("lane two mask not honoured");

   property p_wr_pass;
      @(posedge mclk) disable iff (!rst_b)
         wr_burst && !byte_lane_mask[0] |=>
            wr_en_q[0] && wdata_q == $past(data_lines_in);
   endproperty
   a_wr_pass: assert property (p_wr_pass)
      else $error("unmasked write byte lost");

   property p_wr_idle;
      @(posedge mclk) disable iff (!rst_b)
         !wr_burst |=> wr_en_q == '0 && !wvalid_q;
   endproperty
   a_wr_idle: assert property (p_wr_idle)
      else $error("write enable outside a burst");

   property p_read_hiz;
      @(posedge mclk) disable iff (!rst_b)
         byte_lane_mask[3] ##1 rd_burst |=> data_lines_oe_n[3];
   endproperty
   a_read_hiz: assert property (p_read_hiz)
      else $error("read lane not off");

   property p_read_on;
      @(posedge mclk) disable iff (!rst_b)
         !byte_lane_mask[3] ##1 rd_burst |=> !data_lines_oe_n[3];
   endproperty
   a_read_on: assert property (p_read_on)
      else $error("read lane not driven");

   // Outside a read burst the data pins must never be driven.
   property p_read_idle;
      @(posedge mclk) disable iff (!rst_b)
         !rd_burst |=> data_lines_oe_n == '1;
   endproperty
   a_read_idle: assert property (p_read_idle)
      else $error("data pins driven outside read");

   property p_bank;
      @(posedge mclk) disable iff (!rst_b)
         cmd == CMD_ACT |=> bank_q == $past(bank_select);
   endproperty
   a_bank: assert property (p_bank)
      else $error("bank not captured");

   property p_row;
      @(posedge mclk) disable iff (!rst_b)
         cmd == CMD_ACT |=> act_q && row_q == $past(addr_in);
   endproperty
   a_row: assert property (p_row)
      else $error("row not captured");

   property p_col;
      @(posedge mclk) disable iff (!rst_b)
         cmd == CMD_RD |=> rd_q && col_q == $past(addr_in[COL_W-1:0]);
   endproperty
   a_col: assert property (p_col)
      else $error("column not captured");

   property p_ap;
      @(posedge mclk) disable iff (!rst_b)
         cmd == CMD_WR |=> auto_pre_q == $past(addr_in[PRE_BIT]);
   endproperty
   a_ap: assert property (p_ap)
      else $error("auto precharge flag wrong");

   property p_pre;
      @(posedge mclk) disable iff (!rst_b)
         cmd == CMD_PRE |=> pre_q && pre_all_q == $past(addr_in[PRE_BIT]);
   endproperty
   a_pre: assert property (p_pre)
      else $error("precharge scope wrong");

   property p_mode;
      @(posedge mclk) disable iff (!rst_b)
         cmd == CMD_LMR |=> mode_q == $past({bank_select, addr_in});
   endproperty
   a_mode: assert property (p_mode)
      else $error("mode not loaded");

   property p_cs;
      @(posedge mclk) disable iff (!rst_b)
         cs_n |=> !act_q && !rd_q && !wr_q && !pre_q;
   endproperty
   a_cs: assert property (p_cs)
      else $error("command seen with cs high");
endmodule

// *** verification/sam_ctl_model.sv ***
// Controller model driving command, address and mask pins.
module sam_ctl_model
   import sam_pkg::*;
(
   // Requests.
   input wire logic [3:0] req_cmd,
   input wire logic [MODE_W-1:0] req_op,
   input wire logic [LANES-1:0] req_mask,
   input wire logic req_one,
   // Pins.
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic [ADDR_W-1:0] addr_in,
   output logic [BANK_W-1:0] bank_select,
   output logic [LANES-1:0] byte_lane_mask
);
   timeunit 1ns / 1ps;
   assign {cs_n, ras_n, cas_n, we_n} = req_cmd;
   assign {bank_select, addr_in} = req_op;
   assign byte_lane_mask = req_one ? {LANES{req_mask[0]}} : req_mask;
endmodule

// *** verification/testbench.sv ***
// Random bench for the SDRAM decode block.
module testbench;
   import sam_pkg::*;
   timeunit 1ns / 1ps;
   localparam logic [3:0] TBL [5] = '{CMD_ACT, CMD_RD, CMD_WR,
      CMD_PRE, CMD_LMR};
   logic mclk = 1'h0, rst_b = 1'h0, one = 1'h0, w1 = 1'h0;
   logic rd_burst = 1'h0, wr_burst = 1'h0, b1 = 1'h0;
   logic cs_n, ras_n, cas_n, we_n, act_q, rd_q, wr_q, pre_q;
   logic pre_all_q, auto_pre_q, wvalid_q, ap = 1'h0, pa = 1'h0;
   logic [3:0] cmd = 4'hF, c1 = 4'hF, mk = 4'h0, m1 = 4'h0;
   logic [ADDR_W-1:0] addr_in, row_q, re = 12'h000;
   logic [BANK_W-1:0] bank_select, bank_q;
   logic [LANES-1:0] byte_lane_mask, data_lines_oe_n, wr_en_q, m2;
   logic [DATA_W-1:0] data_lines_out, wdata_q, d1, r1;
   logic [31:0] data_lines_in = 32'h0, rd_data = 32'h0, rs = 32'h79013C88;
   logic [COL_W-1:0] col_q, ce = 8'h00;
   logic [MODE_W-1:0] mode_q, op = 14'h0000, o1, me = MODE_RST;
   int err_count, n_checks;
   sam_ctl_model ctl (.req_cmd(cmd), .req_op(op), .req_mask(mk),
      .req_one(one), .cs_n, .ras_n, .cas_n, .we_n, .addr_in,
      .bank_select, .byte_lane_mask);
   sam_decode dut (.mclk(mclk), .rst_b(rst_b), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .addr_in(addr_in),
      .bank_select(bank_select), .byte_lane_mask(byte_lane_mask),
      .data_lines_in(data_lines_in), .data_lines_out(data_lines_out),
      .data_lines_oe_n(data_lines_oe_n), .rd_burst(rd_burst),
      .wr_burst(wr_burst), .rd_data(rd_data), .act_q(act_q), .rd_q(rd_q),
      .wr_q(wr_q), .pre_q(pre_q), .pre_all_q(pre_all_q), .bank_q(bank_q),
      .row_q(row_q), .col_q(col_q), .auto_pre_q(auto_pre_q),
      .mode_q(mode_q), .wdata_q(wdata_q), .wr_en_q(wr_en_q),
      .wvalid_q(wvalid_q));
   always #5 mclk = ~mclk;
   function logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      return v ^ (v << 5);
   endfunction
   task chk(input logic [31:0] got, exp);
      n_checks++;
      if (got !== exp) err_count++;
      if (got !== exp) $display("[FAIL] %0t got %h exp %h", $time, got, exp);
   endtask
   task rst_chk;
      chk({act_q, rd_q, wr_q, pre_q, pre_all_q, auto_pre_q}, 6'h00);
      chk({wvalid_q, wr_en_q, data_lines_oe_n}, 9'h00F);
      chk({bank_q, row_q, col_q}, 22'h000000);
      chk(mode_q, MODE_RST);
      chk(wdata_q, 32'h0);
      chk(data_lines_out, 32'h0);
   endtask
   task results;
      $display("%0d checks %0d errors", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge mclk);
      rst_b <= 1'h1;
      @(negedge mclk);
      rst_chk;
      $display("reset done");
      repeat (3000) begin
         @(posedge mclk);
         rs = xs(rs);
         cmd <= rs[2:0] < 5 ? TBL[rs[2:0]] : rs[6:3];
         {op, mk, wr_burst, rd_burst, one} <= rs[31:11];
         data_lines_in <= xs(rs);
         rd_data <= xs(~rs);
         @(negedge mclk);
         chk({act_q, rd_q, wr_q, pre_q}, {c1 == CMD_ACT, c1 == CMD_RD,
            c1 == CMD_WR, c1 == CMD_PRE});
         if (c1 == CMD_ACT) re = o1[11:0];
         if (c1 inside {CMD_RD, CMD_WR}) {ap, ce} = {o1[10], o1[7:0]};
         if (c1 == CMD_PRE) pa = o1[10];
         if (c1 == CMD_LMR) me = o1;
         if (c1 inside {TBL} && c1 != CMD_LMR && !(pa && c1 == CMD_PRE))
            chk(bank_q, o1[13:12]);
         chk({row_q, mode_q}, {re, me});
         chk(col_q, ce);
         chk({auto_pre_q, pre_all_q}, {ap, pa});
         chk(wvalid_q, w1);
         if (w1) chk(wdata_q, d1);
         if (w1) chk(wr_en_q, 4'(~m1));
         chk(data_lines_oe_n, b1 ? m2 : 4'hF);
         if (b1) chk(data_lines_out, r1);
         {m2, m1, c1, o1, w1, b1, d1, r1} = {m1, byte_lane_mask, cmd, op,
            wr_burst, rd_burst, data_lines_in, rd_data};
      end
      $display("random done");
      // A reset in mid-run must clear everything the random run left behind.
      @(posedge mclk);
      rst_b <= 1'h0;
      repeat (2) @(posedge mclk);
      rst_b <= 1'h1;
      @(negedge mclk);
      rst_chk;
      $display("mid-run reset done");
      results;
   end
endmodule
